//--- rtl/afe_spi_pkg.sv
// Purpose: shared constants for the ultrasonic front end serial and mode controller
// Assumes: 16-bit serial frames, 250 MHz system clock
// Notes: register offsets and field layouts are shared with the bench
package afe_spi_pkg;

  // frame layout
  localparam int FRAME_BITS = 16;
  localparam int ADDR_BITS = 6;
  localparam int DATA_BITS = 8;
  localparam int STATUS_BITS = 6;
  localparam int RW_BIT = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 9;
  localparam int PAR_BIT = 8;
  localparam logic READ_CMD = 1'b1;
  localparam logic [4:0] CMD_DONE_CNT = 5'h06;
  localparam logic [4:0] LAST_BIT_CNT = 5'h0F;
  localparam logic [4:0] FRAME_CNT = 5'h10;
  localparam logic [4:0] PAR_TX_CNT = 5'h08;

  // register offsets
  localparam logic [5:0] ADDR_DEV_CTRL = 6'h14;
  localparam logic [5:0] ADDR_DRIVE_CTRL = 6'h16;
  localparam logic [5:0] ADDR_ECHO_CFG = 6'h17;
  localparam logic [5:0] ADDR_ZC_CFG = 6'h18;
  localparam logic [5:0] ADDR_DEV_STAT = 6'h1C;

  // field positions
  localparam int CTRL_SLEEP_BIT = 0;
  localparam int CTRL_STANDBY_BIT = 1;
  localparam int CTRL_BURST_BIT = 2;
  localparam logic [7:0] CTRL_STORE_MASK = 8'h03;
  localparam int DRV_DISABLE_BIT = 7;
  localparam int DRV_TARGET_MSB = 3;
  localparam int ECHO_THR_MSB = 2;
  localparam int ECHO_RANGE_BIT = 3;
  localparam int ZC_EN_BIT = 7;
  localparam int ZC_GATE_BIT = 6;
  localparam int ZC_STG_MSB = 5;
  localparam int ZC_STG_LSB = 4;
  localparam int ZC_HYST_MSB = 1;
  localparam int STAT_SUPPLY_BIT = 5;
  localparam int STAT_FAULT_LSB = 2;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DRIVE_RESET = 8'h00;
  localparam logic [7:0] ECHO_RESET = 8'h00;
  localparam logic [7:0] ZC_RESET = 8'h00;

  // reported state codes
  localparam logic [1:0] CODE_LISTEN = 2'h0;
  localparam logic [1:0] CODE_BURST = 2'h1;
  localparam logic [1:0] CODE_STANDBY = 2'h2;
  localparam logic [1:0] CODE_SLEEP = 2'h3;

  // timing
  localparam int WAKE_WAIT_MS = 64;
  localparam int CLK_SYS_MHZ = 250;
  localparam int WAKE_WAIT_CYCLES = WAKE_WAIT_MS * 1000 * CLK_SYS_MHZ;

  typedef enum logic [2:0] {st_wake, st_sleep, st_standby, st_listen, st_burst} mode_state_t;

endpackage : afe_spi_pkg

//--- rtl/afe_spi_mode_ctrl.sv
// Purpose: serial slave, configuration registers and functional-mode sequencing
// Assumes: serial clock idles between frames; chip select low at least 12 ns before first edge
// Notes: serial side runs on the serial clock, everything else on clk_sys_in
`timescale 1ns/1ps

// Contract
// - each transaction is one 16-bit frame each way, full duplex
// - device returns parity error flag, 6 status bits, odd parity, 8 data bits
// - all frame bits travel most significant bit first
// - output launched on rising clock edge, input taken on falling edge
// - transfer starts at chip select fall, ends at chip select rise
// - chip select high resets serial logic and floats serial output
// - write frame data phase echoes the address received in that frame
// - status bit 5 shows drive supply reached its programmed level
// - status bit 4 shows burst ended before full pulse count
// - status bit 3 shows stuck driver fault during burst
// - status bit 2 shows checksum error on internal memory load
// - status bits 1:0 give state: listen 00, burst 01, standby 10, sleep 11
// - sleep by register bit disables major blocks and regulator, serial stays alive
// - leave power-up or sleep on supply level reached or 64 ms, first
// - with regulator disabled leave power-up or sleep at once
// - standby by register bit keeps regulator, shuts other analog blocks
// - neither sleep nor standby gives listen: transmitter idle, receiver active
// - burst entered on burst enable, left at end of burst, both paths active
// - echo interrupt high while envelope above threshold, falls asynchronously
// - zero-cross output off until enabled; stage and hysteresis fields select source
module afe_spi_mode_ctrl #(
  parameter int WAKE_WAIT_CYCLES = afe_spi_pkg::WAKE_WAIT_CYCLES
) (
  // system
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // serial link
  input wire logic spi_sclk_in,
  input wire logic chip_select_n_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  // analog and burst status
  input wire logic drive_supply_level_ok_in,
  input wire logic pulse_count_fault_in,
  input wire logic driver_stuck_fault_in,
  input wire logic eeprom_checksum_fault_in,
  input wire logic burst_end_in,
  input wire logic echo_above_in,
  input wire logic zero_cross_raw_in,
  // analog control
  output logic drive_supply_enable_out,
  output logic [3:0] drive_supply_target_out,
  output logic receive_enable_out,
  output logic transmit_enable_out,
  output logic [2:0] echo_threshold_select_out,
  output logic envelope_range_select_out,
  output logic [1:0] zero_cross_stage_select_out,
  output logic [1:0] zero_cross_hysteresis_out,
  // pins and state
  output logic echo_irq_pin_out,
  output logic zero_cross_pin_out,
  output logic [1:0] functional_state_out
);

  localparam int WAKE_W = $clog2(WAKE_WAIT_CYCLES + 1);
  // nothing is imported, so the state names are brought into scope here
  localparam afe_spi_pkg::mode_state_t st_wake = afe_spi_pkg::st_wake;
  localparam afe_spi_pkg::mode_state_t st_sleep = afe_spi_pkg::st_sleep;
  localparam afe_spi_pkg::mode_state_t st_standby = afe_spi_pkg::st_standby;
  localparam afe_spi_pkg::mode_state_t st_listen = afe_spi_pkg::st_listen;
  localparam afe_spi_pkg::mode_state_t st_burst = afe_spi_pkg::st_burst;

  // serial domain
  logic [4:0] rx_cnt_q;
  logic [14:0] rx_shift_q;
  logic [6:0] cmd_q;
  logic [15:0] hold_word_q;
  logic frame_tog_q;
  logic par_err_q;
  logic [4:0] tx_cnt_q;
  logic sdo_q;
  logic [15:0] rx_word;
  logic [15:0] tx_word;
  logic [7:0] tx_data;
  logic [7:0] rd_data;
  logic tx_par;

  // system domain
  logic [1:0] cs_sync_q;
  logic [1:0] tog_sync_q;
  logic tog_seen_q;
  logic [3:0] in_sync1_q;
  logic [3:0] in_sync2_q;
  logic [7:0] ctrl_q;
  logic [7:0] drive_q;
  logic [7:0] echo_q;
  logic [7:0] zc_q;
  logic [2:0] faults_q;
  logic [2:0] faults_d;
  logic [5:0] status_snap_q;
  logic [5:0] status_now;
  logic [WAKE_W-1:0] wake_cnt_q;
  afe_spi_pkg::mode_state_t state_q;
  afe_spi_pkg::mode_state_t state_d;
  afe_spi_pkg::mode_state_t wake_target;
  logic [1:0] state_code;
  logic frame_evt;
  logic frame_read;
  logic [5:0] frame_addr;
  logic [7:0] frame_data;
  logic write_evt;
  logic stat_clear;
  logic burst_go;
  logic sleep_req;
  logic standby_req;
  logic drive_disable;
  logic supply_ok_s;
  logic wake_done;
  logic wake_ready;

  // ---------------- serial domain ----------------
  assign rx_word = {rx_shift_q, sdi_in};

  // chip select high holds the receive side in reset
  always_ff @(negedge spi_sclk_in or posedge chip_select_n_in) begin
    if (chip_select_n_in) begin
      rx_cnt_q <= '0;
      rx_shift_q <= '0;
      cmd_q <= '0;
    end else if (rx_cnt_q != afe_spi_pkg::FRAME_CNT) begin
      rx_cnt_q <= rx_cnt_q + 5'h01;
      rx_shift_q <= {rx_shift_q[13:0], sdi_in};
      if (rx_cnt_q == afe_spi_pkg::CMD_DONE_CNT) begin
        cmd_q <= {rx_shift_q[5:0], sdi_in};
      end
    end
  end

  // frame hand-off survives chip select; the serial clock stops between frames,
  // so the system reset clears these without a clock
  always_ff @(negedge spi_sclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hold_word_q <= '0;
      frame_tog_q <= 1'b0;
      par_err_q <= 1'b0;
    end else if (!chip_select_n_in && rx_cnt_q == afe_spi_pkg::LAST_BIT_CNT) begin
      hold_word_q <= rx_word;
      frame_tog_q <= ~frame_tog_q;
      par_err_q <= ~(^rx_word);
    end
  end

  // read data is quasi-static: registers only change after the last bit of a frame has been taken
  always_comb begin
    rd_data = 8'h00;
    if (cmd_q[5:0] == afe_spi_pkg::ADDR_DEV_CTRL) begin
      rd_data = ctrl_q;
    end else if (cmd_q[5:0] == afe_spi_pkg::ADDR_DRIVE_CTRL) begin
      rd_data = drive_q;
    end else if (cmd_q[5:0] == afe_spi_pkg::ADDR_ECHO_CFG) begin
      rd_data = echo_q;
    end else if (cmd_q[5:0] == afe_spi_pkg::ADDR_ZC_CFG) begin
      rd_data = zc_q;
    end else if (cmd_q[5:0] == afe_spi_pkg::ADDR_DEV_STAT) begin
      rd_data = {2'h0, status_snap_q};
    end
  end

  assign tx_data = (cmd_q[6] == afe_spi_pkg::READ_CMD) ? rd_data : {2'h0, cmd_q[5:0]};
  assign tx_par = ~(^{par_err_q, status_snap_q, tx_data});
  assign tx_word = {par_err_q, status_snap_q, tx_par, tx_data};

  always_ff @(posedge spi_sclk_in or posedge chip_select_n_in) begin
    if (chip_select_n_in) begin
      tx_cnt_q <= '0;
      sdo_q <= 1'b0;
    end else if (tx_cnt_q != afe_spi_pkg::FRAME_CNT) begin
      sdo_q <= tx_word[4'hF - tx_cnt_q[3:0]];
      tx_cnt_q <= tx_cnt_q + 5'h01;
    end
  end

  assign sdo_out = sdo_q;
  assign sdo_oe_out = ~chip_select_n_in;

  // ---------------- system domain ----------------
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      cs_sync_q <= 2'h3;
      tog_sync_q <= 2'h0;
      tog_seen_q <= 1'b0;
      in_sync1_q <= 4'h0;
      in_sync2_q <= 4'h0;
    end else begin
      cs_sync_q <= {cs_sync_q[0], chip_select_n_in};
      tog_sync_q <= {tog_sync_q[0], frame_tog_q};
      tog_seen_q <= tog_sync_q[1];
      in_sync1_q <= {drive_supply_level_ok_in, pulse_count_fault_in,
                     driver_stuck_fault_in, eeprom_checksum_fault_in};
      in_sync2_q <= in_sync1_q;
    end
  end

  assign frame_evt = tog_sync_q[1] ^ tog_seen_q;
  assign frame_read = hold_word_q[afe_spi_pkg::RW_BIT] == afe_spi_pkg::READ_CMD;
  assign frame_addr = hold_word_q[afe_spi_pkg::ADDR_MSB:afe_spi_pkg::ADDR_LSB];
  assign frame_data = hold_word_q[7:0];
  assign write_evt = frame_evt && !par_err_q && !frame_read;
  assign stat_clear = frame_evt && !par_err_q && frame_read &&
                      frame_addr == afe_spi_pkg::ADDR_DEV_STAT;
  assign burst_go = write_evt && frame_addr == afe_spi_pkg::ADDR_DEV_CTRL &&
                    frame_data[afe_spi_pkg::CTRL_BURST_BIT];
  assign sleep_req = ctrl_q[afe_spi_pkg::CTRL_SLEEP_BIT];
  assign standby_req = ctrl_q[afe_spi_pkg::CTRL_STANDBY_BIT];
  assign drive_disable = drive_q[afe_spi_pkg::DRV_DISABLE_BIT];
  assign supply_ok_s = in_sync2_q[3];

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      ctrl_q <= afe_spi_pkg::CTRL_RESET;
      drive_q <= afe_spi_pkg::DRIVE_RESET;
      echo_q <= afe_spi_pkg::ECHO_RESET;
      zc_q <= afe_spi_pkg::ZC_RESET;
    end else if (write_evt) begin
      if (frame_addr == afe_spi_pkg::ADDR_DEV_CTRL) begin
        ctrl_q <= frame_data & afe_spi_pkg::CTRL_STORE_MASK;
      end else if (frame_addr == afe_spi_pkg::ADDR_DRIVE_CTRL) begin
        drive_q <= frame_data;
      end else if (frame_addr == afe_spi_pkg::ADDR_ECHO_CFG) begin
        echo_q <= frame_data;
      end else if (frame_addr == afe_spi_pkg::ADDR_ZC_CFG) begin
        zc_q <= frame_data;
      end
    end
  end

  // sticky faults: a new event in the clearing cycle wins
  assign faults_d = (faults_q & {3{~stat_clear}}) | in_sync2_q[2:0];

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      faults_q <= 3'h0;
      status_snap_q <= 6'h00;
    end else begin
      faults_q <= faults_d;
      // frozen while a frame runs so the serial side sees a stable word
      if (cs_sync_q[1]) begin
        status_snap_q <= status_now;
      end
    end
  end

  always_comb begin
    state_code = afe_spi_pkg::CODE_SLEEP;
    case (state_q)
      st_listen: state_code = afe_spi_pkg::CODE_LISTEN;
      st_burst: state_code = afe_spi_pkg::CODE_BURST;
      st_standby: state_code = afe_spi_pkg::CODE_STANDBY;
      default: state_code = afe_spi_pkg::CODE_SLEEP;
    endcase
  end

  assign status_now = {supply_ok_s && drive_supply_enable_out, faults_q, state_code};

  // mode sequencing
  assign wake_done = wake_cnt_q == WAKE_W'(WAKE_WAIT_CYCLES - 1);
  assign wake_ready = drive_disable || supply_ok_s || wake_done;
  assign wake_target = standby_req ? st_standby : st_listen;

  always_comb begin
    state_d = state_q;
    case (state_q)
      st_wake: begin
        if (sleep_req) begin
          state_d = st_sleep;
        end else if (wake_ready) begin
          state_d = wake_target;
        end
      end
      st_sleep: begin
        if (!sleep_req) begin
          state_d = drive_disable ? wake_target : st_wake;
        end
      end
      st_standby: begin
        if (sleep_req) begin
          state_d = st_sleep;
        end else if (!standby_req) begin
          state_d = st_listen;
        end
      end
      st_listen: begin
        if (sleep_req) begin
          state_d = st_sleep;
        end else if (standby_req) begin
          state_d = st_standby;
        end else if (burst_go) begin
          state_d = st_burst;
        end
      end
      st_burst: begin
        if (burst_end_in) begin
          state_d = st_listen;
        end
      end
      default: state_d = st_wake;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      state_q <= st_wake;
      wake_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      wake_cnt_q <= (state_q == st_wake && !wake_done) ? wake_cnt_q + WAKE_W'(1) : '0;
    end
  end

  assign drive_supply_enable_out = state_q != st_sleep && !drive_disable;
  assign receive_enable_out = state_q == st_listen || state_q == st_burst;
  assign transmit_enable_out = state_q == st_burst;
  assign functional_state_out = state_code;
  assign drive_supply_target_out = drive_q[afe_spi_pkg::DRV_TARGET_MSB:0];
  assign echo_threshold_select_out = echo_q[afe_spi_pkg::ECHO_THR_MSB:0];
  assign envelope_range_select_out = echo_q[afe_spi_pkg::ECHO_RANGE_BIT];
  assign zero_cross_stage_select_out = zc_q[afe_spi_pkg::ZC_STG_MSB:afe_spi_pkg::ZC_STG_LSB];
  assign zero_cross_hysteresis_out = zc_q[afe_spi_pkg::ZC_HYST_MSB:0];

  // the comparator output is gated, not sampled, so its fall reaches the pin at once
  assign echo_irq_pin_out = echo_above_in && receive_enable_out;
  assign zero_cross_pin_out = zc_q[afe_spi_pkg::ZC_EN_BIT] && zero_cross_raw_in &&
                              (!zc_q[afe_spi_pkg::ZC_GATE_BIT] || echo_irq_pin_out);

  // ---------------- checks ----------------
  property p_tx_odd_parity;
    @(posedge spi_sclk_in) disable iff (chip_select_n_in)
      tx_cnt_q == afe_spi_pkg::PAR_TX_CNT |-> ^tx_word;
  endproperty
  a_tx_odd_parity: assert property (p_tx_odd_parity) else $error("response parity not odd");

  property p_write_echo;
    @(posedge spi_sclk_in) disable iff (chip_select_n_in)
      (tx_cnt_q == afe_spi_pkg::PAR_TX_CNT && cmd_q[6] != afe_spi_pkg::READ_CMD)
      |-> ##3 sdo_q == cmd_q[5] ##1 sdo_q == cmd_q[4];
  endproperty
  a_write_echo: assert property (p_write_echo) else $error("write address not echoed");

  property p_state_code;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      (state_q == st_burst |-> functional_state_out == afe_spi_pkg::CODE_BURST) and
      (state_q == st_listen |-> functional_state_out == afe_spi_pkg::CODE_LISTEN);
  endproperty
  a_state_code: assert property (p_state_code) else $error("state code wrong");

  property p_sleep_off;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      state_q == st_sleep |-> !drive_supply_enable_out && !receive_enable_out;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("blocks active in sleep");

  property p_wake_timeout;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      (state_q == st_wake && !sleep_req && (wake_done || supply_ok_s)) |=> state_q != st_wake;
  endproperty
  a_wake_timeout: assert property (p_wake_timeout) else $error("wake wait overran");

  property p_wake_hold;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      (state_q == st_wake && !sleep_req && !wake_ready) |=> state_q == st_wake;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake left early");

  property p_no_wait_disabled;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      (state_q == st_sleep && !sleep_req && drive_disable)
      |=> state_q == st_standby || state_q == st_listen;
  endproperty
  a_no_wait_disabled: assert property (p_no_wait_disabled) else $error("waited with reg off");

  property p_standby_paths;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      state_q == st_standby |-> !receive_enable_out && !transmit_enable_out &&
                                (drive_supply_enable_out == !drive_disable);
  endproperty
  a_standby_paths: assert property (p_standby_paths) else $error("standby paths wrong");

  property p_listen_default;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      (state_q == st_standby && !standby_req && !sleep_req)
      |=> state_q == st_listen && receive_enable_out && !transmit_enable_out;
  endproperty
  a_listen_default: assert property (p_listen_default) else $error("no listen default");

  sequence s_burst_go;
    state_q == st_listen && burst_go && !sleep_req && !standby_req;
  endsequence
  sequence s_burst_active;
    transmit_enable_out && receive_enable_out && functional_state_out == afe_spi_pkg::CODE_BURST;
  endsequence
  property p_burst_entry;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      s_burst_go |=> s_burst_active;
  endproperty
  a_burst_entry: assert property (p_burst_entry) else $error("burst not entered");

  property p_burst_exit;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      (state_q == st_burst && burst_end_in) |=> state_q == st_listen;
  endproperty
  a_burst_exit: assert property (p_burst_exit) else $error("burst not left");

  property p_pulse_fault_sticky;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      $rose(in_sync2_q[2]) |=> faults_q[2] ##1 status_now[4];
  endproperty
  a_pulse_fault_sticky: assert property (p_pulse_fault_sticky) else $error("fault lost");

  property p_zc_disabled;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      !zc_q[afe_spi_pkg::ZC_EN_BIT] |-> !zero_cross_pin_out;
  endproperty
  a_zc_disabled: assert property (p_zc_disabled) else $error("zero cross not gated");

  property p_parity_discard;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      (frame_evt && par_err_q) |=> $stable(ctrl_q) && $stable(drive_q) && $stable(zc_q);
  endproperty
  a_parity_discard: assert property (p_parity_discard) else $error("bad frame written");

endmodule : afe_spi_mode_ctrl

//--- tb/spi_master_model.sv
// Purpose: serial master model that sends and receives one 16-bit frame per call
// Assumes: link clock idles low and runs only inside a frame, 32 ns period
// Notes: sdi is inverted on deselect so a stale bit never passes for a valid one
`timescale 1ns/1ps
module spi_master_model #(
  parameter int HALF_NS = 16,
  parameter int GAP_NS = 40
) (
  // link pins
  output logic sclk_out,
  output logic chip_select_n_out,
  output logic sdi_out,
  input wire logic sdo_in
);
  initial begin
    sclk_out = 1'b0;
    chip_select_n_out = 1'b1;
    sdi_out = 1'b0;
  end

  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    int i;
    chip_select_n_out = 1'b0;
    #13;
    for (i = 15; i >= 0; i--) begin
      sclk_out = 1'b1;
      sdi_out = tx[i];
      #(HALF_NS);
      sclk_out = 1'b0;
      rx[i] = sdo_in;
      #(HALF_NS);
    end
    chip_select_n_out = 1'b1;
    sdi_out = ~sdi_out;
    // gap covers the system-side hand-off before the next frame
    #(GAP_NS);
  endtask : xfer
endmodule : spi_master_model

//--- tb/test_ultrasonic_afe_spi_mode_ctrl.sv
// Purpose: self-checking bench for the serial slave and mode controller
// Assumes: wake wait shortened to 50 system cycles
// Notes: link traffic comes from the master model, other inputs change on falling clk_sys, except one echo_above drop 1 ns later
`timescale 1ns/1ps
module test_ultrasonic_afe_spi_mode_ctrl;
  logic clk_sys, reset_n, sclk, cs_n, sdi, sdo, sdo_oe, sdo_line;
  logic supply_ok, pc_flt, drv_flt, ee_flt, burst_end, echo_above, zc_raw;
  logic drv_en, rx_en, tx_en, env_rng, irq_pin, zc_pin;
  logic [3:0] drv_tgt;
  logic [2:0] thr;
  logic [1:0] zc_stg, zc_hyst, state;
  logic [15:0] rx;
  int bad_count, num_checks;

  // no pull on the line: a floated sdo reads as the inverse of the flop
  assign sdo_line = sdo_oe ? sdo : ~sdo;

  afe_spi_mode_ctrl #(.WAKE_WAIT_CYCLES(50)) afe_spi_mode_ctrl_i (
    .clk_sys_in(clk_sys), .reset_n_in(reset_n), .spi_sclk_in(sclk),
    .chip_select_n_in(cs_n), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
    .drive_supply_level_ok_in(supply_ok), .pulse_count_fault_in(pc_flt),
    .driver_stuck_fault_in(drv_flt), .eeprom_checksum_fault_in(ee_flt),
    .burst_end_in(burst_end), .echo_above_in(echo_above), .zero_cross_raw_in(zc_raw),
    .drive_supply_enable_out(drv_en), .drive_supply_target_out(drv_tgt),
    .receive_enable_out(rx_en), .transmit_enable_out(tx_en),
    .echo_threshold_select_out(thr), .envelope_range_select_out(env_rng),
    .zero_cross_stage_select_out(zc_stg), .zero_cross_hysteresis_out(zc_hyst),
    .echo_irq_pin_out(irq_pin), .zero_cross_pin_out(zc_pin), .functional_state_out(state));

  spi_master_model spi_master_model_i (
    .sclk_out(sclk), .chip_select_n_out(cs_n), .sdi_out(sdi), .sdo_in(sdo_line));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [15:0] mk(logic rw, logic [5:0] a, logic [7:0] d, logic flip);
    return {rw, a, flip ^ ~^{rw, a, d}, d};
  endfunction : mk

  task automatic xf(input logic rw, input logic [5:0] a, input logic [7:0] d, input logic flip);
    spi_master_model_i.xfer(mk(rw, a, d, flip), rx);
    chk({15'h0, ^rx}, 16'h0001);
    repeat (8) @(negedge clk_sys);
  endtask : xf

  task automatic t_wake;
    int n;
    n = 0;
    chk({14'h0, sdo_oe, sdo}, 16'h0000);
    chk({13'h0, state, drv_en}, 16'h0007);
    while (state !== afe_spi_pkg::CODE_LISTEN && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    chk({15'h0, n >= 45 && n <= 58}, 16'h0001);
    chk({14'h0, rx_en, tx_en}, 16'h0002);
    $display("t_wake done");
  endtask : t_wake

  task automatic t_regs;
    xf(0, afe_spi_pkg::ADDR_DRIVE_CTRL, 8'h05, 0);
    chk({15'h0, rx[7:0] == {2'b00, afe_spi_pkg::ADDR_DRIVE_CTRL}}, 16'h0001);
    chk({9'h0, rx[15:9]}, 16'h0000);
    chk({12'h0, drv_tgt}, 16'h0005);
    xf(1, afe_spi_pkg::ADDR_DRIVE_CTRL, 8'h00, 0);
    chk({8'h0, rx[7:0]}, 16'h0005);
    xf(1, 6'h3F, 8'h00, 0);
    chk({8'h0, rx[7:0]}, 16'h0000);
    xf(0, afe_spi_pkg::ADDR_ECHO_CFG, 8'h0D, 1);
    chk({13'h0, thr}, 16'h0000);
    xf(0, afe_spi_pkg::ADDR_ECHO_CFG, 8'h0D, 0);
    chk({15'h0, rx[15]}, 16'h0001);
    chk({12'h0, env_rng, thr}, 16'h000D);
    xf(1, afe_spi_pkg::ADDR_ECHO_CFG, 8'h00, 0);
    chk({15'h0, rx[15]}, 16'h0000);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_modes;
    int n;
    n = 0;
    xf(0, afe_spi_pkg::ADDR_DEV_CTRL, 8'h02, 0);
    chk({12'h0, state, drv_en, rx_en}, 16'h000A);
    xf(0, afe_spi_pkg::ADDR_DEV_CTRL, 8'h01, 0);
    chk({12'h0, state, drv_en, rx_en}, 16'h000C);
    xf(1, afe_spi_pkg::ADDR_DEV_STAT, 8'h00, 0);
    chk({8'h0, rx[7:0]}, 16'h0003);
    xf(0, afe_spi_pkg::ADDR_DEV_CTRL, 8'h00, 0);
    chk({12'h0, state, drv_en, rx_en}, 16'h000E);
    supply_ok = 1'b1;
    while (state !== afe_spi_pkg::CODE_LISTEN && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    chk({15'h0, n <= 6}, 16'h0001);
    xf(1, afe_spi_pkg::ADDR_DEV_STAT, 8'h00, 0);
    chk({8'h0, rx[7:0]}, 16'h0020);
    supply_ok = 1'b0;
    xf(0, afe_spi_pkg::ADDR_DRIVE_CTRL, 8'h80, 0);
    xf(0, afe_spi_pkg::ADDR_DEV_CTRL, 8'h01, 0);
    xf(0, afe_spi_pkg::ADDR_DEV_CTRL, 8'h00, 0);
    chk({14'h0, state}, 16'h0000);
    $display("t_modes done");
  endtask : t_modes

  task automatic t_burst;
    int i;
    xf(0, afe_spi_pkg::ADDR_DEV_CTRL, 8'h04, 0);
    chk({12'h0, state, rx_en, tx_en}, 16'h0007);
    echo_above = 1'b1;
    #1 chk({15'h0, irq_pin}, 16'h0001);
    echo_above = 1'b0;
    #1 chk({15'h0, irq_pin}, 16'h0000);
    @(negedge clk_sys);
    burst_end = 1'b1;
    @(negedge clk_sys);
    burst_end = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk({12'h0, state, rx_en, tx_en}, 16'h0002);
    // each read also clears the fault seen before, so one flag at a time shows
    for (i = 0; i < 3; i++) begin
      {pc_flt, drv_flt, ee_flt} = 3'b100 >> i;
      repeat (3) @(negedge clk_sys);
      {pc_flt, drv_flt, ee_flt} = 3'b000;
      xf(1, afe_spi_pkg::ADDR_DEV_STAT, 8'h00, 0);
      chk({8'h0, rx[7:0]}, {8'h0, 8'h10 >> i});
    end
    $display("t_burst done");
  endtask : t_burst

  task automatic t_zc;
    zc_raw = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk({15'h0, zc_pin}, 16'h0000);
    xf(0, afe_spi_pkg::ADDR_ZC_CFG, 8'hB2, 0);
    chk({11'h0, zc_pin, zc_stg, zc_hyst}, 16'h001E);
    xf(0, afe_spi_pkg::ADDR_ZC_CFG, 8'hF2, 0);
    chk({15'h0, zc_pin}, 16'h0000);
    echo_above = 1'b1;
    #1 chk({15'h0, zc_pin}, 16'h0001);
    $display("t_zc done");
  endtask : t_zc

  task automatic summarize;
    $display("checks=%0d bad=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial begin
    {reset_n, supply_ok, pc_flt, drv_flt, ee_flt, burst_end, echo_above, zc_raw} = 8'h00;
    bad_count = 0;
    num_checks = 0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'b1;
    t_wake;
    t_regs;
    t_modes;
    t_burst;
    t_zc;
    summarize;
  end

  // about 20 frames of 0.6 us plus the waits need well under a fifth of this
  initial begin
    #100000;
    bad_count++;
    $display("watchdog expired");
    summarize;
  end
endmodule : test_ultrasonic_afe_spi_mode_ctrl
